// >>> verilog/ppl_host.sv
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ppl_cfg.svh"
module ppl_host #(
	parameter int DW     = 32,
	parameter int CFG_LO = `CFG_LOW_CYC,
	parameter int CF2CK  = `CF2CK_CYC,
	parameter int ST2CK  = `ST2CK_CYC
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	ppl_if.host                link,
	input  wire logic [7:0]    awaddr,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	output logic [1:0]         bresp,
	output logic               bvalid,
	input  wire logic          bready,
	input  wire logic [7:0]    araddr,
	input  wire logic          arvalid,
	output logic               arready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	output logic               rvalid,
	input  wire logic          rready
);
	initial begin
		if (DW > 32)
			$error("host bus width over 32 not served");
	end
	typedef struct packed {
		ppl_pkg::host_state_t st;
		logic [31:0] cnt;
		logic [2:0]  div;
		logic [3:0]  edges;
		logic        ck;
		logic        rn;
		logic        watch;
		logic [3:0]  ratio;
		logic [DW-1:0] dat;
		logic        dfull;
		logic [15:0] sent;
		logic [1:0]  sr_s;
		logic [1:0]  cd_s;
		logic        aw_h;
		logic [7:0]  aw_a;
		logic        w_h;
		logic [31:0] w_d;
		logic        bv;
		logic [1:0]  br;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
	} host_st_t;
	host_st_t s_q;
	host_st_t s_d;

	assign awready   = !s_q.aw_h && !s_q.bv;
	assign wready    = !s_q.w_h && !s_q.bv;
	assign arready   = !s_q.rv;

	always_comb begin
		s_d      = s_q;
		s_d.sr_s = {s_q.sr_s[0], link.status_ready};
		s_d.cd_s = {s_q.cd_s[0], link.load_done};
		s_d.cnt  = s_q.cnt + 32'h1;
		//----------------------------------------
		// AXI4-Lite slave
		//----------------------------------------
		if (awvalid && awready) begin
			s_d.aw_h = 1'b1;
			s_d.aw_a = awaddr;
		end
		if (wvalid && wready) begin
			s_d.w_h = 1'b1;
			s_d.w_d = wdata;
		end
		if (s_q.aw_h && s_q.w_h) begin
			s_d.aw_h = 1'b0;
			s_d.w_h  = 1'b0;
			s_d.bv   = 1'b1;
			s_d.br   = 2'b00;
			case (s_q.aw_a)
				`REG_CTRL: begin
					s_d.watch = s_q.w_d[`CTRL_WATCH];
					s_d.ratio = s_q.w_d[`CTRL_RATIO_LSB +: 4];
					if (s_q.w_d[`CTRL_START]) begin
						s_d.st  = ppl_pkg::H_PULSE;
						s_d.rn  = 1'b0;
						s_d.cnt = '0;
						s_d.sent = '0;
					end
				end
				`REG_DATA: begin
					if (s_q.dfull)
						s_d.br = 2'b10;
					else begin
						s_d.dat   = s_q.w_d[DW-1:0];
						s_d.dfull = 1'b1;
					end
				end
				default: s_d.br = 2'b10;
			endcase
		end
		if (s_q.bv && bready)
			s_d.bv = 1'b0;
		if (arvalid && arready) begin
			s_d.rv = 1'b1;
			s_d.rr = 2'b00;
			case (araddr)
				`REG_CTRL:   s_d.rd = {24'h0, s_q.ratio, 2'b00,
				                       s_q.watch, 1'b0};
				`REG_STATUS: s_d.rd = {27'h0, s_q.dfull, s_q.cd_s[1],
				                       s_q.sr_s[1], s_q.st == ppl_pkg::H_DONE,
				                       s_q.st != ppl_pkg::H_IDLE};
				`REG_COUNT:  s_d.rd = {16'h0, s_q.sent};
				default: begin
					s_d.rd = '0;
					s_d.rr = 2'b10;
				end
			endcase
		end
		if (s_q.rv && rready)
			s_d.rv = 1'b0;
		//----------------------------------------
		// Link sequencer
		//----------------------------------------
		case (s_q.st)
			ppl_pkg::H_IDLE: ;
			ppl_pkg::H_PULSE: begin
				if (s_q.cnt >= 32'(CFG_LO)) begin
					s_d.rn  = 1'b1;
					s_d.cnt = '0;
					s_d.st  = ppl_pkg::H_WAIT;
				end
			end
			ppl_pkg::H_WAIT: begin
				// Watching host keys off the wire, else off the clock
				if (s_q.watch) begin
					if (!s_q.sr_s[1])
						s_d.cnt = '0;
					else if (s_q.cnt >= 32'(ST2CK))
						s_d.st = ppl_pkg::H_SEND;
				end else if (s_q.cnt >= 32'(CF2CK)) begin
					s_d.st = ppl_pkg::H_SEND;
				end
				s_d.div   = '0;
				s_d.edges = '0;
			end
			ppl_pkg::H_SEND: begin
				if (s_q.div != 3'(`HALF_DIV - 1)) begin
					s_d.div = s_q.div + 3'h1;
				end else if (s_q.ck || s_q.edges != 4'h0 ||
				             s_q.dfull) begin
					// Low phase stretches until a word is loaded
					s_d.div = '0;
					s_d.ck  = !s_q.ck;
					// Rising edge: word held for ratio periods
					if (!s_q.ck) begin
						if (s_q.edges + 4'h1 >= s_q.ratio) begin
							s_d.edges = '0;
							s_d.dfull = 1'b0;
							s_d.sent  = s_q.sent + 16'h1;
						end else
							s_d.edges = s_q.edges + 4'h1;
					end
				end
				// Stop only between words, with the clock low
				if (s_q.cd_s[1] && s_q.edges == 4'h0 && !s_q.ck &&
				    !s_d.ck)
					s_d.st = ppl_pkg::H_DONE;
			end
			ppl_pkg::H_DONE: s_d.ck = 1'b0;
			default: s_d.st = ppl_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q       <= '0;
			s_q.st    <= ppl_pkg::H_IDLE;
			s_q.rn    <= 1'b1;
			s_q.ratio <= 4'h1;
			s_q.sr_s  <= 2'b00;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.restart_n    = s_q.rn;
	assign link.config_clock = s_q.ck;
	assign link.data         = s_q.dat;
	assign bvalid            = s_q.bv;
	assign bresp             = s_q.br;
	assign rvalid            = s_q.rv;
	assign rdata             = s_q.rd;
	assign rresp             = s_q.rr;
endmodule // ppl_host
`default_nettype wire

// >>> pkg/ppl_cfg.svh
`ifndef PPL_CFG_SVH
`define PPL_CFG_SVH
// Times in their own units, cycle counts derived at 50 MHz
`define CLK_MHZ            50
`define FAST_POR_MIN_MS    4
`define FAST_POR_MAX_MS    12
`define STD_POR_MIN_MS     100
`define STD_POR_MAX_MS     300
`define CF2CD_MAX_NS       600
`define CF2ST0_MAX_NS      600
`define CFG_LOW_MIN_US     2
`define STATUS_LOW_MIN_US  268
`define STATUS_LOW_MAX_US  1506
`define CF2CK_MIN_US       1506
`define ST2CK_MIN_US       2
`define CD2UM_MIN_US       175
`define CD2UM_MAX_US       437
// Fast POR: 8 ms, inside 4..12 ms
`define FAST_POR_CYC       (8 * 1000 * `CLK_MHZ)
// Standard POR: 200 ms, inside 100..300 ms
`define STD_POR_CYC        (200 * 1000 * `CLK_MHZ)
`define STATUS_LOW_CYC     (`STATUS_LOW_MIN_US * `CLK_MHZ + 32)
`define CD2UM_CYC          (`CD2UM_MIN_US * `CLK_MHZ + 100)
`define CFG_LOW_CYC        (`CFG_LOW_MIN_US * `CLK_MHZ)
`define CF2CK_CYC          (`CF2CK_MIN_US * `CLK_MHZ + 50)
`define ST2CK_CYC          (`ST2CK_MIN_US * `CLK_MHZ + 10)
// Host clock divider half period: 4 cycles -> 80 ns, 6.25 MHz
`define HALF_DIV           4
// Host register offsets
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_DATA           8'h08
`define REG_COUNT          8'h0c
// Control bits
`define CTRL_START         0
`define CTRL_WATCH         1
`define CTRL_RATIO_LSB     4
`endif

// >>> pkg/ppl_pkg.sv
package ppl_pkg;
	typedef enum logic [2:0] {
		D_POR    = 3'b000,
		D_RESET  = 3'b001,
		D_STLOW  = 3'b010,
		D_LOAD   = 3'b011,
		D_INIT   = 3'b100,
		D_USER   = 3'b101
	} dev_state_t;
	typedef enum logic [2:0] {
		H_IDLE   = 3'b000,
		H_PULSE  = 3'b001,
		H_WAIT   = 3'b010,
		H_SETTLE = 3'b011,
		H_SEND   = 3'b100,
		H_DONE   = 3'b101
	} host_state_t;
endpackage

// >>> pkg/ppl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ppl_if #(parameter int DW = 32);
	logic          restart_n;
	logic          config_clock;
	logic [DW-1:0] data;
	logic          status_o;
	logic          status_oe;
	logic          status_ext_oe;
	logic          load_done;
	logic          user_mode;
	// Open-drain status: low while anyone drives it
	wire           status_ready = !(status_oe || status_ext_oe);
	modport dev (
		input  restart_n, config_clock, data, status_ready,
		output status_o, status_oe, load_done, user_mode
	);
	modport host (
		output restart_n, config_clock, data,
		input  status_ready, load_done, user_mode
	);
endinterface
`default_nettype wire

// >>> verilog/ppl_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ppl_fifo #(
	parameter int W = 32,
	parameter int D = 4
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	initial begin
		if (D < 2 || (1 << AW) != D)
			$error("ppl_fifo depth must be a power of two");
	end
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} fifo_st_t;
	fifo_st_t      s_q;
	fifo_st_t      s_d;
	logic [W-1:0]  mem [D];
	logic          full;
	logic          empty;

	assign full      = (s_q.wp[AW] != s_q.rp[AW]) &&
	                   (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
	assign empty     = (s_q.wp == s_q.rp);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[s_q.rp[AW-1:0]];

	always_comb begin
		s_d = s_q;
		if (in_valid && !full)
			s_d.wp = s_q.wp + 1'b1;
		if (out_ready && !empty)
			s_d.rp = s_q.rp + 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
		if (in_valid && !full)
			mem[s_q.wp[AW-1:0]] <= in_data;
	end
endmodule // ppl_fifo
`default_nettype wire

// >>> verilog/ppl_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppl_cfg.svh"
module passive_parallel_config_sequencer #(
	parameter int DW       = 32,
	parameter int NWORDS   = 16,
	parameter int FAST_POR = `FAST_POR_CYC,
	parameter int STD_POR  = `STD_POR_CYC,
	parameter int ST_LOW   = `STATUS_LOW_CYC,
	parameter int CD2UM    = `CD2UM_CYC
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	ppl_if.dev                 link,
	input  wire logic          scheme_select_pins,
	input  wire logic [3:0]    ratio,
	output logic               word_valid,
	input  wire logic          word_ready,
	output logic [DW-1:0]      word_data,
	output logic [15:0]        word_count
);
	//----------------------------------------
	// Parameter checks
	//----------------------------------------
	initial begin
		if (!(DW == 8 || DW == 16 || DW == 32))
			$error("bus width must be 8, 16 or 32");
		if (NWORDS < 1)
			$error("word count must be positive");
		if (FAST_POR < 1 ||
		    FAST_POR > `FAST_POR_MAX_MS * 1000 * `CLK_MHZ)
			$error("fast power-on delay out of range");
		if (STD_POR < FAST_POR ||
		    STD_POR > `STD_POR_MAX_MS * 1000 * `CLK_MHZ)
			$error("standard power-on delay out of range");
		if (ST_LOW < 1 || ST_LOW > `STATUS_LOW_MAX_US * `CLK_MHZ)
			$error("status low span out of range");
		if (CD2UM < 1 || CD2UM > `CD2UM_MAX_US * `CLK_MHZ)
			$error("user mode delay out of range");
	end
	typedef struct packed {
		ppl_pkg::dev_state_t st;
		logic [31:0]         cnt;
		logic [3:0]          phase;
		logic [15:0]         words;
		logic [2:0]          rst_s;
		logic [2:0]          clk_s;
		logic [1:0]          sr_s;
		logic [1:0]          sel_s;
		logic [1:0][DW-1:0]  dat_s;
		logic [DW-1:0]       data;
		logic                push;
		logic                done;
		logic                user;
		logic                oe;
	} dev_st_t;
	dev_st_t       s_q;
	dev_st_t       s_d;
	logic          fifo_in_ready;
	logic          restart_low;
	logic          clk_rise;
	logic          ext_ready;
	logic [31:0]   por_len;

	assign restart_low = !s_q.rst_s[1];
	// Edge of the synced clock, seen two cycles late
	assign clk_rise    = s_q.clk_s[1] && !s_q.clk_s[2];
	assign ext_ready   = s_q.sr_s[1];
	assign por_len     = s_q.sel_s[1] ? 32'(STD_POR)
	                                  : 32'(FAST_POR);

	always_comb begin
		s_d       = s_q;
		s_d.push  = 1'b0;
		s_d.cnt   = s_q.cnt + 32'h1;
		//----------------------------------------
		// Pin synchronisers
		//----------------------------------------
		// Data rides two stages like its clock, so the word taken
		// at a detected edge is the one that stood at that edge
		s_d.rst_s = {s_q.rst_s[1:0], link.restart_n};
		s_d.clk_s = {s_q.clk_s[1:0], link.config_clock};
		s_d.sr_s  = {s_q.sr_s[0], link.status_ready};
		s_d.sel_s = {s_q.sel_s[0], scheme_select_pins};
		s_d.dat_s = {s_q.dat_s[0], link.data};
		//----------------------------------------
		// Sequencer
		//----------------------------------------
		case (s_q.st)
			ppl_pkg::D_POR: begin
				// Restart is not looked at until power-on ends
				s_d.oe = 1'b1;
				if (s_q.cnt >= por_len) begin
					s_d.st  = ppl_pkg::D_STLOW;
					s_d.cnt = '0;
				end
			end
			ppl_pkg::D_RESET: begin
				if (!restart_low) begin
					s_d.st  = ppl_pkg::D_STLOW;
					s_d.cnt = '0;
				end
			end
			ppl_pkg::D_STLOW: begin
				if (s_q.cnt >= 32'(ST_LOW))
					s_d.oe = 1'b0;
				// Wait on the wire too: an outside party may hold it
				if (!s_q.oe && ext_ready) begin
					s_d.st    = ppl_pkg::D_LOAD;
					s_d.phase = '0;
					s_d.words = '0;
				end
			end
			ppl_pkg::D_LOAD: begin
				if (clk_rise) begin
					// One word every ratio edges; extra edges decode
					if (s_q.phase == 4'h0 && fifo_in_ready) begin
						s_d.data  = s_q.dat_s[1];
						s_d.push  = 1'b1;
						s_d.words = s_q.words + 16'h1;
					end
					if (s_q.phase + 4'h1 >= ratio)
						s_d.phase = '0;
					else
						s_d.phase = s_q.phase + 4'h1;
				end
				if (s_q.words >= 16'(NWORDS)) begin
					s_d.done = 1'b1;
					s_d.st   = ppl_pkg::D_INIT;
					s_d.cnt  = '0;
				end
			end
			ppl_pkg::D_INIT: begin
				if (s_q.cnt >= 32'(CD2UM)) begin
					s_d.user = 1'b1;
					s_d.st   = ppl_pkg::D_USER;
				end
			end
			ppl_pkg::D_USER: ;
			default: s_d.st = ppl_pkg::D_RESET;
		endcase
		// Restart overrides every state, outside power-on
		if (restart_low && s_q.st != ppl_pkg::D_POR) begin
			s_d.st   = ppl_pkg::D_RESET;
			s_d.oe   = 1'b1;
			s_d.done = 1'b0;
			s_d.user = 1'b0;
			s_d.cnt  = '0;
			// Count belongs to the load now starting
			s_d.words = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q       <= '0;
			s_q.st    <= ppl_pkg::D_POR;
			s_q.oe    <= 1'b1;
			s_q.rst_s <= 3'b111;
			s_q.sr_s  <= 2'b11;
		end else begin
			s_q <= s_d;
		end
	end

	//----------------------------------------
	// Word buffer
	//----------------------------------------
	// Four words ride out a consumer that stalls for a short burst
	ppl_fifo #(.W(DW), .D(4)) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (s_q.push),
		.in_ready  (fifo_in_ready),
		.in_data   (s_q.data),
		.out_valid (word_valid),
		.out_ready (word_ready),
		.out_data  (word_data)
	);

	//----------------------------------------
	// Link outputs
	//----------------------------------------
	assign link.status_o  = 1'b0;
	assign link.status_oe = s_q.oe;
	assign link.load_done = s_q.done;
	assign link.user_mode = s_q.user;
	assign word_count     = s_q.words;
endmodule // passive_parallel_config_sequencer
`default_nettype wire

// >>> testbench/ppl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ppl_chk #(
	parameter int CFG_LO = 100,
	parameter int ST_LOW = 40,
	parameter int ST2CK  = 20,
	parameter int CD2UM  = 30
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic restart_n,
	input wire logic config_clock,
	input wire logic status_oe,
	input wire logic status_ready,
	input wire logic load_done,
	input wire logic user_mode
);
	localparam int REL_HI = ST_LOW + 8;
	localparam int UM_HI  = CD2UM + 8;
	logic [31:0] low_q, sto_q, sth_q, don_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------------------------------------
	// Span counters, too long for repetition
	// ------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_q <= '0;
			sto_q <= '0;
			sth_q <= '0;
			don_q <= '0;
		end else begin
			low_q <= restart_n ? '0 : low_q + 1;
			sto_q <= (!restart_n || !status_oe) ? '0 : sto_q + 1;
			sth_q <= !status_ready ? '0 : sth_q + 1;
			don_q <= load_done ? don_q + 1 : '0;
		end
	end
	property p_cd_drop;
		$fell(restart_n) |-> ##[0:30] !load_done;
	endproperty
	a_cd_drop: assert property (p_cd_drop) else $error("done kept");
	property p_st_pull;
		$fell(restart_n) |-> ##[0:30] status_oe;
	endproperty
	a_st_pull: assert property (p_st_pull) else $error("status kept");
	property p_cfg_low;
		$rose(restart_n) |-> low_q >= CFG_LO;
	endproperty
	a_cfg_low: assert property (p_cfg_low) else $error("short pulse");
	property p_st_min;
		$fell(status_oe) |-> sto_q >= ST_LOW;
	endproperty
	a_st_min: assert property (p_st_min) else $error("status short");
	property p_st_rel;
		$rose(restart_n) |-> ##[1:REL_HI] !status_oe;
	endproperty
	a_st_rel: assert property (p_st_rel) else $error("status late");
	property p_first_ck;
		$rose(config_clock) |-> status_ready && sth_q >= ST2CK;
	endproperty
	a_first_ck: assert property (p_first_ck) else $error("early clock");
	property p_ck_rate;
		$rose(config_clock) |-> config_clock[*4] ##1 !config_clock;
	endproperty
	a_ck_rate: assert property (p_ck_rate) else $error("clock fast");
	property p_um_late;
		$rose(load_done) |-> ##[1:UM_HI] user_mode;
	endproperty
	a_um_late: assert property (p_um_late) else $error("user late");
	property p_um_early;
		$rose(user_mode) |-> don_q >= CD2UM;
	endproperty
	a_um_early: assert property (p_um_early) else $error("user early");
	property p_done_hold;
		load_done && restart_n |=> load_done;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("done lost");
endmodule // ppl_chk
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int NW = 4;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic scheme = 1'b0;
	logic [3:0] ratio = 4'h1;
	logic word_valid, word_ready = 1'b1;
	logic [31:0] word_data;
	logic [15:0] word_count;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
	logic arvalid = 0, arready, rvalid, rready = 0;
	logic [1:0] bresp, rresp;
	logic [31:0] got [$];
	int num_errors = 0;
	int samples_checked = 0;
	always #10 aclk = ~aclk;
	ppl_if link_bus();
	passive_parallel_config_sequencer #(.NWORDS(NW), .FAST_POR(50),
		.ST_LOW(40), .CD2UM(30))
	u_passive_parallel_config_sequencer (.aclk(aclk), .aresetn(aresetn),
		.link(link_bus), .scheme_select_pins(scheme), .ratio(ratio),
		.word_valid(word_valid), .word_ready(word_ready),
		.word_data(word_data), .word_count(word_count));
	ppl_host #(.CF2CK(100)) u_ppl_host (
		.aclk(aclk), .aresetn(aresetn), .link(link_bus),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	ppl_chk u_ppl_chk (.aclk(aclk), .aresetn(aresetn),
		.restart_n(link_bus.restart_n), .config_clock(link_bus.config_clock),
		.status_oe(link_bus.status_oe), .status_ready(link_bus.status_ready),
		.load_done(link_bus.load_done), .user_mode(link_bus.user_mode));
	always @(posedge aclk) if (aresetn && word_valid && word_ready)
		got.push_back(word_data);
	// ------------------------------------------
	// Bus cycles and comparison
	// ------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// ------------------------------------------
	// Scenarios
	// ------------------------------------------
	task automatic t_por(input logic sel);
		aresetn <= 1'b0;
		scheme <= sel;
		link_bus.status_ext_oe <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("status at reset", link_bus.status_ready, 0);
		chk("done at reset", link_bus.load_done, 0);
		repeat (150) @(posedge aclk);
		chk("status after por", link_bus.status_ready, !sel);
	endtask
	task automatic t_load(input logic [3:0] rt, input logic w, hold);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		got.delete();
		ratio <= rt;
		word_ready <= !hold;
		link_bus.status_ext_oe <= hold;
		wr(8'h00, {24'h0, rt, 2'b00, w, 1'b1}, r);
		chk("ctrl resp", r, 2'b00);
		if (hold) begin
			repeat (250) @(posedge aclk);
			rd(8'h04, d, r);
			chk("status held", d[2], 0);
			chk("count held", word_count, 0);
			link_bus.status_ext_oe <= 1'b0;
		end
		for (int i = 0; i < NW; i++)
			do wr(8'h08, {24'hc0de00, rt, i[3:0]}, r); while (r !== 2'b00);
		do rd(8'h04, d, r); while (d[1] !== 1'b1);
		chk("done seen", d[3], 1);
		chk("word count", word_count, NW);
		rd(8'h0c, d, r);
		chk("count reg", d, NW);
		n = 0;
		while (link_bus.user_mode !== 1'b1 && n < 60) begin
			@(posedge aclk);
			n++;
		end
		chk("user mode", link_bus.user_mode, 1);
		word_ready <= 1'b1;
		repeat (12) @(posedge aclk);
		chk("words out", got.size(), NW);
		foreach (got[i]) chk("word", got[i], {24'hc0de00, rt, i[3:0]});
	endtask
	task automatic t_after();
		logic [31:0] d;
		logic [1:0] r;
		wr(8'h08, 32'h0badf00d, r);
		repeat (100) @(posedge aclk);
		chk("late word", word_count, NW);
		chk("done kept", link_bus.load_done, 1);
		rd(8'h20, d, r);
		chk("unmapped", r, 2'b10);
	endtask
	task automatic test_done();
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		t_por(1'b0);
		t_load(4'h1, 1'b1, 1'b0);
		t_load(4'h3, 1'b0, 1'b0);
		t_load(4'h2, 1'b1, 1'b1);
		t_after();
		t_por(1'b1);
		test_done();
	end
	// Whole run is under 2000 cycles; generous margin
	initial begin
		repeat (60000) @(posedge aclk);
		num_errors++;
		test_done();
	end
endmodule // testbench
`default_nettype wire
